// >>> pkg/pao_pkg.sv
/*
  constants and types for the pipelined converter output port.
  assumes one system clock; the conversion clock arrives on a pin.
*/
package pao_pkg;
  localparam int PAO_CODE_W = 10;
  localparam int PAO_LATENCY = 2;
  localparam logic [PAO_CODE_W-1:0] PAO_CODE_RST = 10'h000;
  localparam logic [1:0] PAO_FILL_RST = 2'h0;
  localparam logic [1:0] PAO_FILL_FULL = 2'h2;
  typedef logic [PAO_CODE_W-1:0] pao_code_t;
endpackage

// >>> pkg/pao_stage_if.sv
/*
  interface between the port top and its pipeline stage.
  assumes both ends on clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface pao_stage_if;
  import pao_pkg::*;
  logic adv;
  pao_code_t din;
  pao_code_t dout;
  modport stage (input adv, input din, output dout);
  modport ctrl (output adv, output din, input dout);
endinterface
`default_nettype wire

// >>> rtl/pao_stage.sv
/*
  one pipeline register stage, advancing on a strobe.
  assumes the strobe comes from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pao_stage
  import pao_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  pao_stage_if.stage sif
);
  pao_code_t word_q;
  pao_code_t word_d;

  // hold unless strobed
  always_comb begin
    word_d = sif.adv ? sif.din : word_q;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_q <= PAO_CODE_RST;
    end else begin
      word_q <= word_d;
    end
  end

  assign sif.dout = word_q;
endmodule
`default_nettype wire

// >>> rtl/pao_top.sv
/*
  digital output port of a pipelined converter: samples the quantised
  input on conversion clock falling edges and presents it two cycles later.
  holds two pin synchronisers for the controls, a retimer for the input,
  two pipeline stages, the output word and its per-line enables, and a
  refill counter that raises pipe_valid on the second fall after standby,
  a fall before the first new sample reaches sample_code.
  assumes conv_clk and control pins are asynchronous to clk and much slower.
  assumes each conv_clk phase lasts at least three clk periods, so the
  edge detector cannot miss an edge, and that the far side resolves the
  per-line enables into the real pin levels.
*/
`timescale 1ns/1ps
`default_nettype none
module pao_top
  import pao_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic conv_clk,
  input wire logic standby_request,
  input wire logic out_enable_n,
  input wire logic [PAO_CODE_W-1:0] analog_level,
  output logic [PAO_CODE_W-1:0] sample_code,
  output logic [PAO_CODE_W-1:0] sample_code_oe,
  output logic pipe_valid
);
  // conversion clock pin: two sync flops, then one more to see the edge
  logic [2:0] clk_sync_q;
  logic [2:0] clk_sync_d;
  // standby pin synchroniser
  logic [1:0] sb_sync_q;
  logic [1:0] sb_sync_d;
  // output enable pin synchroniser
  logic [1:0] oe_sync_q;
  logic [1:0] oe_sync_d;
  // quantised input retimed through two flops
  pao_code_t ain1_q;
  pao_code_t ain1_d;
  pao_code_t ain2_q;
  pao_code_t ain2_d;
  // word and enables as they leave the port
  pao_code_t out_q;
  pao_code_t out_d;
  logic [PAO_CODE_W-1:0] oe_q;
  logic [PAO_CODE_W-1:0] oe_d;
  // refill tracking after standby
  logic [1:0] fill_q;
  logic [1:0] fill_d;
  logic valid_q;
  logic valid_d;
  // decoded strobes and levels
  logic fall;
  logic sb;
  logic drive;

  // one interface per pipeline stage
  pao_stage_if s0 ();
  pao_stage_if s1 ();

  // shift the conversion clock pin in; edge is read between flops two and three
  always_comb begin
    clk_sync_d = {clk_sync_q[1:0], conv_clk};
  end

  // cleared at reset so a pin that idles either way cannot fake a falling edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_sync_q <= '0;
    end else begin
      clk_sync_q <= clk_sync_d;
    end
  end

  // standby pin synchroniser
  always_comb begin
    sb_sync_d = {sb_sync_q[0], standby_request};
  end

  // reset to standby so nothing is driven until the pin is seen low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sb_sync_q <= '1;
    end else begin
      sb_sync_q <= sb_sync_d;
    end
  end

  // output enable pin synchroniser
  always_comb begin
    oe_sync_d = {oe_sync_q[0], out_enable_n};
  end

  // reset to disabled; enable is active low
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_sync_q <= '1;
    end else begin
      oe_sync_q <= oe_sync_d;
    end
  end

  // retime the quantised input; it lags the pin by as many flops as the
  // clock edge does, so the sample stage always takes a settled word
  always_comb begin
    ain1_d = analog_level;
    ain2_d = ain1_q;
  end

  // input retiming registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ain1_q <= PAO_CODE_RST;
      ain2_q <= PAO_CODE_RST;
    end else begin
      ain1_q <= ain1_d;
      ain2_q <= ain2_d;
    end
  end

  // synchronised standby level
  assign sb = sb_sync_q[1];

  // falling edge of the conversion clock; frozen in standby so the
  // pipeline keeps its contents and no word moves while powered down
  assign fall = clk_sync_q[2] & ~clk_sync_q[1] & ~sb;

  // pins drive only while both controls are low; standby wins over
  // the enable, so a stray enable cannot wake the drivers
  assign drive = ~sb & ~oe_sync_q[1];

  // sample stage takes the retimed input, straight binary with no recoding
  assign s0.adv = fall;
  assign s0.din = ain2_q;

  // second stage supplies the two-edge latency
  assign s1.adv = fall;
  assign s1.din = s0.dout;

  // sample stage
  pao_stage u_sample (
    .clk(clk),
    .sys_rst(sys_rst),
    .sif(s0)
  );

  // latency stage
  pao_stage u_delay (
    .clk(clk),
    .sys_rst(sys_rst),
    .sif(s1)
  );

  // output word moves on the same strobe, right after each falling edge
  always_comb begin
    out_d = out_q;
    if (fall) begin
      out_d = s1.dout;
    end
  end

  // output word register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_q <= PAO_CODE_RST;
    end else begin
      out_q <= out_d;
    end
  end

  // one enable per data line, all from the same level
  always_comb begin
    oe_d = {PAO_CODE_W{drive}};
  end

  // enables stay off through reset so the lines float
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oe_q <= '0;
    end else begin
      oe_q <= oe_d;
    end
  end

  // count falls since standby; stops at full so it cannot wrap
  always_comb begin
    fill_d = fill_q;
    if (sb) begin
      fill_d = PAO_FILL_RST;
    end else if (fall && fill_q != PAO_FILL_FULL) begin
      fill_d = fill_q + 2'h1;
    end
  end

  // refill counter register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fill_q <= PAO_FILL_RST;
    end else begin
      fill_q <= fill_d;
    end
  end

  // valid once refilled and the pins are driven
  always_comb begin
    valid_d = (fill_d == PAO_FILL_FULL) & drive;
  end

  // valid flag register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  // pins come straight from flops
  assign sample_code = out_q;
  assign sample_code_oe = oe_q;
  assign pipe_valid = valid_q;
endmodule
`default_nettype wire

// >>> verif/pao_top_assertions.sv
/* port checker for pao_top, bound in below.
   assumes conv_clk phases of 5 clk. */
`timescale 1ns/1ps
`default_nettype none
module pao_chk
  import pao_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic conv_clk,
  input wire logic standby_request,
  input wire logic out_enable_n,
  input wire logic [PAO_CODE_W-1:0] sample_code,
  input wire logic [PAO_CODE_W-1:0] sample_code_oe,
  input wire logic pipe_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // drive and float against the pins
  AST_OE_ON: assert property ((!standby_request && !out_enable_n)[*5] |=> &sample_code_oe)
    else $error("not driving");
  AST_OE_OFF: assert property (out_enable_n[*5] |=> sample_code_oe == '0)
    else $error("driving while disabled");
  AST_SB_OFF: assert property (standby_request[*5] |=> !sample_code_oe && !pipe_valid)
    else $error("driving in standby");
  AST_SB_HOLD: assert property (standby_request[*8] |=> $stable(sample_code))
    else $error("converting in standby");
  // word changes once, early in the low phase
  AST_UPD_EDGE: assert property (
    !$stable(sample_code) |-> !conv_clk && $past(conv_clk, 6))
    else $error("update off edge");
  AST_ONE_UPD: assert property (!$stable(sample_code) |=> $stable(sample_code)[*5])
    else $error("double update");
  AST_OE_ALL: assert property (sample_code_oe == '0 || &sample_code_oe)
    else $error("split enable");
  cover property (!$stable(sample_code) && &sample_code_oe);
  cover property ($fell(pipe_valid) ##[1:20] standby_request);
  cover property ($rose(pipe_valid));
endmodule
bind pao_top pao_chk pao_chk_inst(.clk, .sys_rst, .conv_clk, .standby_request, .out_enable_n,
  .sample_code, .sample_code_oe, .pipe_valid);
`default_nettype wire

// >>> verif/pao_capture.sv
/* capture side: makes conv_clk, latches the resolved word.
   assumes clk from the bench. */
`timescale 1ns/1ps
`default_nettype none
module pao_capture
  import pao_pkg::*;
(
  input wire logic clk,
  input wire logic [PAO_CODE_W-1:0] sample_code,
  input wire logic [PAO_CODE_W-1:0] sample_code_oe,
  output logic conv_clk,
  output logic cap,
  output pao_code_t word
);
  logic [2:0] n = 3'h0;
  pao_code_t bus = '0;
  initial conv_clk = 1'b1;
  initial cap = 1'b0;
  // 5 clk phases; latch on the rise, away from the update
  always @(posedge clk) begin
    n <= (n == 3'h4) ? 3'h0 : n + 3'h1;
    cap <= (n == 3'h4) && !conv_clk;
    if (n == 3'h4) conv_clk <= ~conv_clk;
    if (n == 3'h4 && !conv_clk) word <= bus;
    bus <= (sample_code & sample_code_oe) | (~bus & ~sample_code_oe); // floats toggle
  end
endmodule
`default_nettype wire

// >>> verif/pao_top_tb.sv
/* self-checking bench for pao_top.
   assumes pao_capture makes conv_clk. */
`timescale 1ns/1ps
`default_nettype none
module pao_top_tb;
  import pao_pkg::*;
  logic clk = 0, sys_rst = 1, standby_request = 0, out_enable_n = 0, cc_q = 1;
  logic conv_clk, cap, pipe_valid;
  pao_code_t analog_level = '0, sample_code, sample_code_oe, word, exp_q[$];
  logic [15:0] rs = 16'h61B1;
  int n_fail = 0, check_count = 0, k = 0;
  pao_top pao_top_inst(.clk, .sys_rst, .conv_clk, .standby_request, .out_enable_n,
    .analog_level, .sample_code, .sample_code_oe, .pipe_valid);
  pao_capture pao_capture_inst(.clk, .sample_code, .sample_code_oe, .conv_clk, .cap, .word);
  initial forever #10 clk = ~clk;
  function automatic pao_code_t xs();
    rs ^= rs << 7;
    rs ^= rs >> 9;
    rs ^= rs << 8;
    return rs[9:0];
  endfunction
  task automatic check(input logic [PAO_CODE_W:0] got, input logic [PAO_CODE_W:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic rises(input int m);
    int lim;
    lim = 20 * m;
    for (int i = 0; i < lim && m > 0; i++) begin
      @(posedge clk);
      if (cap) m--;
    end
    if (m > 0) begin
      n_fail++;
      finish_test;
    end
  endtask
  // new level on each rise, noted at each taken fall
  always @(posedge clk) begin
    cc_q <= conv_clk;
    if (conv_clk && !cc_q) begin
      k <= k + 1;
      analog_level <= (k % 7 < 2) ? {10{k[0]}} : xs();
    end
    if (!conv_clk && cc_q && !sys_rst && !standby_request && !out_enable_n) begin
      exp_q.push_back(analog_level);
    end
  end
  // compare each captured word with the note of two falls before; first two discarded
  always @(posedge clk) begin
    if (cap && exp_q.size() == 3) begin
      check({pipe_valid, word}, {1'b1, exp_q.pop_front()});
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rises(40);
    $display("test stream done");
    standby_request <= 1'b1;
    exp_q.delete();
    rises(4);
    check({pipe_valid, sample_code_oe}, '0);
    standby_request <= 1'b0;
    rises(20);
    $display("test standby done");
    out_enable_n <= 1'b1;
    exp_q.delete();
    rises(3);
    check({pipe_valid, sample_code_oe}, '0);
    out_enable_n <= 1'b0;
    exp_q.delete();
    rises(20);
    $display("test enable done");
    finish_test;
  end
endmodule
`default_nettype wire
